// ===== mmvsd_decode.sv
// address region decoder
`default_nettype none

module mmvsd_decode
	import mmvsd_pkg::*;
(
	// access
	input  wire logic [15:0] i_addr,
	input  wire logic        i_wr,
	// region selects
	output logic             o_ram,
	output logic             o_dpage,
	output logic             o_mon,
	output logic             o_vec,
	output logic             o_rom_wr
);

	always_comb begin
		o_ram    = (i_addr >= RAM_LO) && (i_addr <= RAM_HI);
		o_dpage  = o_ram && (i_addr <= DPAGE_END);
		o_mon    = (i_addr >= MON_LO) && (i_addr <= MON_HI);
		o_vec    = i_addr >= VEC_ASER_TX;
		o_rom_wr = o_mon && i_wr;
	end

endmodule : mmvsd_decode

`default_nettype wire

// ===== mmvsd_mem.sv
// asynchronous read memory behind the stack and vector port
`default_nettype none

module mmvsd_mem (
	// clock
	input  wire logic        i_clk,
	// access
	input  wire logic [15:0] i_addr,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [7:0]  i_wdata,
	// read data
	output logic      [7:0]  o_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] mem [65536];
	logic [7:0] last;

	// known fill so vector slots hold a checkable pattern
	initial begin
		last = 8'h00;
		for (int i = 0; i < 65536; i++) begin
			mem[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
		end
	end

	always @(posedge i_clk) begin
		if (i_wr) begin
			mem[i_addr] <= i_wdata;
		end
		if (i_rd) begin
			last <= o_rdata;
		end
	end

	// released bus shows the inverse of the last byte
	assign o_rdata = i_rd ? mem[i_addr] : ~last;

endmodule : mmvsd_mem

`default_nettype wire

// ===== mmvsd_pkg.sv
// constants and types for memory map, vector and stack decode
// Contract
// - Every access from 0x0060 to 0x035F, 768 bytes, selects read/write RAM.
// - The RAM lying in the first 256-byte page gives 160 direct-page bytes.
// - The 240 bytes from 0xFE10 to 0xFEFF decode as read-only monitor ROM.
// - The stack pointer is 16 bits wide and may point anywhere in 64 KB.
// - Reset puts the stack pointer at 0x00FF.
// - Interrupt entry pushes exactly five bytes before the handler runs.
// - The upper index byte is not among the bytes saved on interrupt entry.
// - A subroutine call pushes a two-byte return address.
// - Each push decrements the stack pointer and each pull increments it.
// - Reset, software, pin and clock synthesiser vectors sit at FFFE..FFF8.
// - Faults four..one use FFF0..FFF6 and the motor PWM unit uses FFEE.
// - First timer: channels 0..3 at FFEC..FFE6 and overflow at FFE4.
// - Second timer: channel 0 at FFE2, channel 1 at FFE0, overflow FFDE.
// - Converter FFDC, sync serial rx FFDA / tx FFD8, async err/rx/tx D6..D2.
`default_nettype none

package mmvsd_pkg;

	localparam logic [15:0] RAM_LO        = 16'h0060;
	localparam logic [15:0] RAM_HI        = 16'h035f;
	localparam logic [15:0] DPAGE_END     = 16'h00ff;
	localparam logic [15:0] MON_LO        = 16'hfe10;
	localparam logic [15:0] MON_HI        = 16'hfeff;
	localparam logic [15:0] SP_RESET      = 16'h00ff;

	// fixed vector slots, each the even (high byte) address
	localparam logic [15:0] VEC_RESET     = 16'hfffe;
	localparam logic [15:0] VEC_FAULT4    = 16'hfff0;
	localparam logic [15:0] VEC_MOTOR_PWM = 16'hffee;
	localparam logic [15:0] VEC_TA_OVF    = 16'hffe4;
	localparam logic [15:0] VEC_TB_OVF    = 16'hffde;
	localparam logic [15:0] VEC_ASER_TX   = 16'hffd2;

	localparam logic [2:0]  INT_PUSH_BYTES  = 3'h5;
	localparam logic [2:0]  CALL_PUSH_BYTES = 3'h2;
	localparam logic [2:0]  ONE_PUSH_BYTES  = 3'h1;

	// order matters: slot address is VEC_RESET minus twice the index
	typedef enum logic [4:0] {
		SRC_RESET, SRC_SWI, SRC_EXT_IRQ, SRC_CLK_SYN,
		SRC_FAULT1, SRC_FAULT2, SRC_FAULT3, SRC_FAULT4,
		SRC_MOTOR_PWM,
		SRC_TA_CH0, SRC_TA_CH1, SRC_TA_CH2, SRC_TA_CH3, SRC_TA_OVF,
		SRC_TB_CH0, SRC_TB_CH1, SRC_TB_OVF,
		SRC_CONV, SRC_SSER_RX, SRC_SSER_TX,
		SRC_ASER_ERR, SRC_ASER_RX, SRC_ASER_TX
	} mmvsd_src_type;

endpackage : mmvsd_pkg

`default_nettype wire

// ===== mmvsd_top.sv
// stack sequencer, vector fetch and map decode for the core
`default_nettype none

module mmvsd_top
	import mmvsd_pkg::*;
(
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	// core access decode
	input  wire logic [15:0] i_acc_addr,
	input  wire logic        i_acc_wr,
	output logic             o_sel_ram,
	output logic             o_sel_dpage,
	output logic             o_sel_mon,
	output logic             o_sel_vec,
	output logic             o_rom_wr_err,
	// stack pointer control
	input  wire logic        i_sp_load,
	input  wire logic [15:0] i_sp_val,
	input  wire logic        i_push,
	input  wire logic [7:0]  i_push_data,
	input  wire logic        i_pull,
	output logic      [7:0]  o_pull_data,
	output logic             o_pull_valid,
	output logic      [15:0] o_sp,
	output logic             o_sp_in_ram,
	// context entry requests
	input  wire logic        i_int_req,
	input  wire logic [4:0]  i_int_src,
	input  wire logic        i_call_req,
	input  wire logic [15:0] i_pc,
	input  wire logic [7:0]  i_x,
	input  wire logic [7:0]  i_a,
	input  wire logic [7:0]  i_ccr,
	output logic             o_busy,
	// memory port
	output logic      [15:0] o_mem_addr,
	output logic             o_mem_wr,
	output logic             o_mem_rd,
	output logic      [7:0]  o_mem_wdata,
	input  wire logic [7:0]  i_mem_rdata,
	// fetched vector
	output logic      [15:0] o_vec_addr,
	output logic             o_vec_valid
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PUSH,
		ST_VHI,
		ST_VLO,
		ST_PULL
	} mmvsd_state_type;

	mmvsd_state_type state_ff;
	mmvsd_state_type nxt_state;
	logic [2:0]      cnt_ff;
	logic            vec_pend_ff;
	logic [4:0]      src_ff;
	logic [15:0]     sp_ff;
	logic [39:0]     shift_ff;
	logic [7:0]      vec_hi_ff;
	logic [15:0]     vec_addr_ff;
	logic            vec_valid_ff;
	logic [7:0]      pull_data_ff;
	logic            pull_valid_ff;
	logic [15:0]     vec_slot;
	logic            idle;
	logic            int_go;
	logic            call_go;
	logic            pull_go;
	logic            push_go;
	logic            load_go;

	// access decode for the core
	mmvsd_decode u_acc_dec (
		.i_addr   (i_acc_addr),
		.i_wr     (i_acc_wr),
		.o_ram    (o_sel_ram),
		.o_dpage  (o_sel_dpage),
		.o_mon    (o_sel_mon),
		.o_vec    (o_sel_vec),
		.o_rom_wr (o_rom_wr_err)
	);

	// flags a stack pointer off RAM, outcome left to software
	mmvsd_decode u_sp_dec (
		.i_addr   (sp_ff),
		.i_wr     (1'b0),
		.o_ram    (o_sp_in_ram),
		.o_dpage  (),
		.o_mon    (),
		.o_vec    (),
		.o_rom_wr ()
	);

	mmvsd_vec u_vec (
		.i_src  (src_ff),
		.o_slot (vec_slot)
	);

	// request arbitration, interrupt first
	always_comb begin
		idle    = state_ff == ST_IDLE;
		int_go  = idle && i_int_req;
		call_go = idle && !i_int_req && i_call_req;
		pull_go = idle && !i_int_req && !i_call_req && i_pull;
		push_go = idle && !i_int_req && !i_call_req && !i_pull && i_push;
		load_go = idle && !i_int_req && !i_call_req && !i_pull && !i_push
			&& i_sp_load;
	end

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (int_go || call_go || push_go) begin
					nxt_state = ST_PUSH;
				end else if (pull_go) begin
					nxt_state = ST_PULL;
				end
			end
			ST_PUSH: begin
				if (cnt_ff == ONE_PUSH_BYTES) begin
					nxt_state = vec_pend_ff ? ST_VHI : ST_IDLE;
				end
			end
			ST_VHI:  nxt_state = ST_VLO;
			ST_VLO:  nxt_state = ST_IDLE;
			ST_PULL: nxt_state = ST_IDLE;
		endcase
	end

	// reset starts with the reset vector fetch
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state_ff <= ST_VHI;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// byte count and pending vector after the pushes
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			cnt_ff      <= 3'h0;
			vec_pend_ff <= 1'b0;
			src_ff      <= 5'(SRC_RESET);
		end else if (int_go) begin
			cnt_ff      <= INT_PUSH_BYTES;
			vec_pend_ff <= 1'b1;
			src_ff      <= i_int_src;
		end else if (call_go) begin
			cnt_ff      <= CALL_PUSH_BYTES;
		end else if (push_go) begin
			cnt_ff      <= ONE_PUSH_BYTES;
		end else if (state_ff == ST_PUSH) begin
			cnt_ff      <= cnt_ff - 3'h1;
		end else if (state_ff == ST_VHI) begin
			vec_pend_ff <= 1'b0;
		end
	end

	// stack pointer
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			sp_ff <= SP_RESET;
		end else if (load_go) begin
			sp_ff <= i_sp_val;
		end else if (state_ff == ST_PUSH) begin
			sp_ff <= sp_ff - 16'h0001;
		end else if (pull_go) begin
			sp_ff <= sp_ff + 16'h0001;
		end
	end

	// bytes to push, low byte first; upper index byte never loaded
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			shift_ff <= 40'h0;
		end else if (int_go) begin
			shift_ff <= {i_ccr, i_a, i_x, i_pc[15:8], i_pc[7:0]};
		end else if (call_go) begin
			shift_ff <= {24'h0, i_pc[15:8], i_pc[7:0]};
		end else if (push_go) begin
			shift_ff <= {32'h0, i_push_data};
		end else if (state_ff == ST_PUSH) begin
			shift_ff <= {8'h00, shift_ff[39:8]};
		end
	end

	// vector fetch, high byte first
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			vec_hi_ff    <= 8'h00;
			vec_addr_ff  <= 16'h0000;
			vec_valid_ff <= 1'b0;
		end else begin
			vec_valid_ff <= state_ff == ST_VLO;
			if (state_ff == ST_VHI) begin
				vec_hi_ff <= i_mem_rdata;
			end
			if (state_ff == ST_VLO) begin
				vec_addr_ff <= {vec_hi_ff, i_mem_rdata};
			end
		end
	end

	// pulled byte
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			pull_data_ff  <= 8'h00;
			pull_valid_ff <= 1'b0;
		end else begin
			pull_valid_ff <= state_ff == ST_PULL;
			if (state_ff == ST_PULL) begin
				pull_data_ff <= i_mem_rdata;
			end
		end
	end

	// memory port driven from state registers
	always_comb begin
		o_mem_wr    = state_ff == ST_PUSH;
		o_mem_rd    = (state_ff == ST_VHI) || (state_ff == ST_VLO)
			|| (state_ff == ST_PULL);
		o_mem_wdata = shift_ff[7:0];
		unique case (state_ff)
			ST_VHI:  o_mem_addr = vec_slot;
			ST_VLO:  o_mem_addr = {vec_slot[15:1], 1'b1};
			default: o_mem_addr = sp_ff;
		endcase
	end

	assign o_sp         = sp_ff;
	assign o_busy       = !idle;
	assign o_vec_addr   = vec_addr_ff;
	assign o_vec_valid  = vec_valid_ff;
	assign o_pull_data  = pull_data_ff;
	assign o_pull_valid = pull_valid_ff;

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_sys_rst);

	AST_RAM_MAP: assert property (
		o_sel_ram == ((i_acc_addr >= RAM_LO) && (i_acc_addr <= RAM_HI)))
		else $error("ram select wrong");

	AST_DPAGE_MAP: assert property (
		o_sel_dpage == (o_sel_ram && (i_acc_addr[15:8] == 8'h00)))
		else $error("direct page select wrong");

	AST_MON_MAP: assert property (
		(i_acc_wr && i_acc_addr >= MON_LO && i_acc_addr <= MON_HI)
		|-> o_sel_mon && o_rom_wr_err && !o_sel_ram)
		else $error("monitor rom decode wrong");

	AST_SP_LOAD: assert property (
		load_go |=> o_sp == $past(i_sp_val))
		else $error("stack pointer load lost");

	AST_SP_RESET: assert property (
		$past(i_sys_rst) |-> o_sp == SP_RESET && o_sp_in_ram)
		else $error("stack pointer reset value wrong");

	AST_INT_FIVE: assert property (
		int_go |=> o_mem_wr [*5] ##1 (!o_mem_wr && o_mem_rd))
		else $error("interrupt entry not five pushes");

	AST_INT_DEPTH: assert property (
		int_go |-> ##6 o_sp == $past(o_sp, 6) - 16'h0005)
		else $error("interrupt stack depth wrong");

	AST_NO_UPPER_INDEX: assert property (
		int_go |=> o_mem_wdata == $past(i_pc[7:0])
		##3 o_mem_wdata == $past(i_a, 4)
		##1 o_mem_wdata == $past(i_ccr, 5))
		else $error("interrupt frame content wrong");

	AST_CALL_TWO: assert property (
		call_go |=> o_mem_wr [*2] ##1 !o_mem_wr)
		else $error("call not two pushes");

	AST_PUSH_DEC: assert property (
		o_mem_wr |-> o_mem_addr == o_sp ##1 o_sp == $past(o_sp) - 16'h0001)
		else $error("push did not decrement");

	AST_PULL_INC: assert property (
		pull_go |=> o_mem_rd && o_mem_addr == $past(o_sp) + 16'h0001
		##1 o_pull_valid)
		else $error("pull did not increment");

	AST_RESET_VEC: assert property (
		($past(i_sys_rst) && !i_sys_rst)
		|-> o_mem_rd && o_mem_addr == VEC_RESET ##2 o_vec_valid)
		else $error("reset vector fetch wrong");

	AST_VEC_FAULT: assert property (
		(state_ff == ST_VHI && src_ff == 5'(SRC_FAULT4))
		|-> o_mem_addr == VEC_FAULT4)
		else $error("fault four slot wrong");

	AST_VEC_MOTOR: assert property (
		(state_ff == ST_VHI && src_ff == 5'(SRC_MOTOR_PWM))
		|-> o_mem_addr == VEC_MOTOR_PWM)
		else $error("motor pwm slot wrong");

	AST_VEC_TIMA: assert property (
		(state_ff == ST_VHI && src_ff == 5'(SRC_TA_OVF))
		|-> o_mem_addr == VEC_TA_OVF)
		else $error("first timer overflow slot wrong");

	AST_VEC_TIMB: assert property (
		(state_ff == ST_VHI && src_ff == 5'(SRC_TB_OVF))
		|-> o_mem_addr == VEC_TB_OVF)
		else $error("second timer overflow slot wrong");

	AST_VEC_SER: assert property (
		(state_ff == ST_VHI && src_ff == 5'(SRC_ASER_TX))
		|-> o_mem_addr == VEC_ASER_TX)
		else $error("serial transmit slot wrong");

	AST_VEC_JOIN: assert property (
		o_vec_valid |-> !$past(o_mem_addr[0], 2) && $past(o_mem_addr[0])
		&& o_vec_addr == {$past(i_mem_rdata, 2), $past(i_mem_rdata)})
		else $error("vector bytes joined wrong");

endmodule : mmvsd_top

`default_nettype wire

// ===== mmvsd_top_tb.sv
// self-checking bench for map decode, vectors and stack
`default_nettype none

module mmvsd_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk, rst, acc_wr, sp_load, push, pull, int_req, call_req;
	logic [15:0] acc_addr, sp_val, pc, sp, mem_addr, vec_addr, va, spm, e;
	logic [7:0] push_data, x, a, ccr, pull_data, mem_wdata, mem_rdata;
	logic [4:0] int_src, de;
	logic sel_ram, sel_dpage, sel_mon, sel_vec, rom_err, pull_valid;
	logic sp_in_ram, busy, mem_wr, mem_rd, vec_valid, m;
	logic [23:0] wq [$];
	logic [7:0] stk [$];
	logic [7:0] ctx [5];
	logic [15:0] bnd [12] = '{16'h005f, 16'h0060, 16'h00ff, 16'h0100,
		16'h035f, 16'h0360, 16'hfe0f, 16'hfe10, 16'hfeff, 16'hff00,
		16'hffd1, 16'hffd2};
	// even slot address for each source index, in package enum order
	logic [15:0] slot [23] = '{16'hfffe, 16'hfffc, 16'hfffa, 16'hfff8,
		16'hfff6, 16'hfff4, 16'hfff2, 16'hfff0, 16'hffee, 16'hffec,
		16'hffea, 16'hffe8, 16'hffe6, 16'hffe4, 16'hffe2, 16'hffe0,
		16'hffde, 16'hffdc, 16'hffda, 16'hffd8, 16'hffd6, 16'hffd4,
		16'hffd2};
	int err_count = 0;
	int tests_run = 0;

	mmvsd_top i_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_acc_addr(acc_addr),
		.i_acc_wr(acc_wr), .o_sel_ram(sel_ram), .o_sel_dpage(sel_dpage),
		.o_sel_mon(sel_mon), .o_sel_vec(sel_vec), .o_rom_wr_err(rom_err),
		.i_sp_load(sp_load), .i_sp_val(sp_val), .i_push(push),
		.i_push_data(push_data), .i_pull(pull), .o_pull_data(pull_data),
		.o_pull_valid(pull_valid), .o_sp(sp), .o_sp_in_ram(sp_in_ram),
		.i_int_req(int_req), .i_int_src(int_src), .i_call_req(call_req),
		.i_pc(pc), .i_x(x), .i_a(a), .i_ccr(ccr), .o_busy(busy),
		.o_mem_addr(mem_addr), .o_mem_wr(mem_wr), .o_mem_rd(mem_rd),
		.o_mem_wdata(mem_wdata), .i_mem_rdata(mem_rdata),
		.o_vec_addr(vec_addr), .o_vec_valid(vec_valid));

	mmvsd_mem i_mem (.i_clk(clk), .i_addr(mem_addr), .i_wr(mem_wr),
		.i_rd(mem_rd), .i_wdata(mem_wdata), .o_rdata(mem_rdata));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// every stack write seen on the memory port
	always @(posedge clk) begin
		if (rst === 1'b0 && mem_wr === 1'b1) begin
			wq.push_back({mem_addr, mem_wdata});
		end
	end

	function automatic logic [7:0] f(logic [15:0] q);
		return q[7:0] ^ q[15:8] ^ 8'h5a;
	endfunction : f

	task automatic results();
		$display("errors=%0d checks=%0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : results

	task automatic chk(logic [23:0] g, logic [23:0] w);
		tests_run++;
		if (g !== w) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, g, w);
			err_count++;
		end
	endtask : chk

	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick

	task automatic idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 20) begin
			tick();
			n++;
			if (vec_valid === 1'b1) va = vec_addr;
		end
		chk(24'(busy), 24'h0);
	endtask : idle

	task automatic load(logic [15:0] v);
		sp_val = v;
		sp_load = 1'b1;
		tick();
		sp_load = 1'b0;
		spm = v;
		chk(sp, v);
		chk(sp_in_ram, 1);
	endtask : load

	task automatic rstseq(int c);
		rst = 1'b1;
		repeat (c) tick();
		rst = 1'b0;
		va = 'x;
		idle();
		chk(sp, 16'h00ff);
		chk(va, {f(16'hfffe), f(16'hffff)});
	endtask : rstseq

	initial begin
		#200000;
		err_count++;
		results();
	end

	initial begin
		{acc_wr, sp_load, push, pull, int_req, call_req} = '0;
		{acc_addr, sp_val, pc, push_data, x, a, ccr, int_src} = '0;
		void'($urandom(32'h4a17));
		rstseq(20);
		for (int i = 0; i < 40; i++) begin
			acc_addr = (i < 12) ? bnd[i] : 16'($urandom);
			acc_wr = (i == 7) || 1'($urandom);
			tick();
			e = acc_addr;
			m = e >= 16'hfe10 && e <= 16'hfeff;
			de = {e >= 16'h60 && e <= 16'h35f, e >= 16'h60 && e <= 16'hff,
				m, e >= 16'hffd2, m && acc_wr};
			chk({sel_ram, sel_dpage, sel_mon, sel_vec, rom_err}, de);
		end
		for (int s = 0; s < 24; s++) begin
			load(16'h0100 + 16'($urandom % 'h250));
			pc = 16'($urandom);
			{x, a, ccr} = 24'($urandom);
			ctx = '{pc[7:0], pc[15:8], x, a, ccr};
			int_src = 5'(s);
			int_req = 1'b1;
			wq.delete();
			va = 'x;
			tick();
			int_req = 1'b0;
			idle();
			e = (s > 22) ? 16'hfffe : slot[s];
			chk(24'(wq.size()), 5);
			foreach (wq[k]) chk(wq[k], {spm - 16'(k), ctx[k]});
			chk(sp, spm - 16'h5);
			chk(va, {f(e), f(e + 16'h1)});
			spm = spm - 16'h5;
		end
		pc = 16'($urandom);
		wq.delete();
		call_req = 1'b1;
		tick();
		call_req = 1'b0;
		idle();
		chk(24'(wq.size()), 2);
		chk(wq[0], {spm, pc[7:0]});
		chk(wq[1], {spm - 16'h1, pc[15:8]});
		chk(sp, spm - 16'h2);
		load(16'h0200 + 16'($urandom % 'h100));
		repeat (8) begin
			push_data = 8'($urandom);
			stk.push_back(push_data);
			push = 1'b1;
			tick();
			push = 1'b0;
			idle();
			chk(wq.pop_back(), {spm, push_data});
			spm--;
			chk(sp, spm);
		end
		repeat (8) begin
			pull = 1'b1;
			tick();
			pull = 1'b0;
			tick();
			chk({pull_valid, pull_data}, {1'b1, stk.pop_back()});
			spm++;
			chk(sp, spm);
			idle();
		end
		rstseq(2);
		results();
	end

endmodule : mmvsd_top_tb

`default_nettype wire

// ===== mmvsd_vec.sv
// vector source to slot address lookup
`default_nettype none

module mmvsd_vec
	import mmvsd_pkg::*;
(
	// source
	input  wire logic [4:0]  i_src,
	// even slot address
	output logic      [15:0] o_slot
);

	logic [4:0] idx;

	always_comb begin
		// unknown sources fall back to the reset slot
		idx = (i_src > 5'(SRC_ASER_TX)) ? 5'(SRC_RESET) : i_src;
		o_slot = VEC_RESET - {10'h000, idx, 1'b0};
	end

endmodule : mmvsd_vec

`default_nettype wire
